// ---- inc/dump_init_pkg.sv ----
// Purpose: Constants for the initialization-parameter dump command handler.
// Assumes: Parameter block is 16-bit word addressed; short I/O takes 16-bit words at byte offsets.
// Notes: Block word offsets follow the command parameter block layout.
package dump_init_pkg;
  localparam logic [15:0] CMD_DUMP_INIT = 16'h0043;
  localparam logic [3:0] W_CMD = 4'h0;
  localparam logic [3:0] W_OPT = 4'h1;
  localparam logic [3:0] W_STATUS = 4'h2;
  localparam logic [3:0] W_VEC = 4'h4;
  localparam logic [3:0] W_IRQ_PRIORITY_LEVEL = 4'h5;
  localparam logic [3:0] W_MEMTYPE = 4'h7;
  localparam logic [3:0] W_BUF_HI = 4'h8;
  localparam logic [3:0] W_BUF_LO = 4'h9;
  localparam logic [3:0] W_LEN_HI = 4'hA;
  localparam logic [3:0] W_LEN_LO = 4'hB;
  localparam logic [3:0] LAST_IN_WORD = 4'hB;
  localparam int OPT_IRQ_ENABLE_BIT = 0;
  localparam logic [15:0] OPT_RSV_MASK = 16'hFFFE;
  localparam logic [15:0] IRQ_PRIORITY_LEVEL_RSV_MASK = 16'hFFF8;
  localparam logic [15:0] MEMTYPE_RSV_MASK = 16'hF000;
  localparam logic [15:0] MEMTYPE_AM_MASK = 16'h00FF;
  localparam logic [15:0] TRANSFER_KIND_SELECT_MASK = 16'h0C00;
  localparam logic [15:0] MEMORY_SPACE_SELECT_MASK = 16'h0300;
  localparam logic [15:0] MEMORY_SPACE_SHORT_IO = 16'h0300;
  localparam logic [4:0] LIST_WORDS = 5'h14;
  localparam logic [31:0] BYTES_PER_WORD = 32'h00000002;
  localparam logic [15:0] ST_OK = 16'h0000;
  localparam logic [15:0] ST_BAD_CODE = 16'h0001;
  localparam logic [15:0] ST_BAD_PARAM = 16'h0002;
  localparam logic [15:0] ST_SHORT_LEN = 16'h0003;
endpackage

// ---- design/dump_init_params_cmd.sv ----
// Purpose: Executes the dump-initialization-parameters command from a parameter block.
// Assumes: The block words arrive on a read port with data one cycle later.
// Notes: The parameter list is presented on a word input indexed by list word.
//   Completion is signalled one cycle after the status write strobe.
// Function
// R1 - Code 0x43 in word 0 selects the dump command.
// R2 - Option bit 0 enables the completion interrupt; clear means none.
// R3 - Host zeros reserved bits in options, level and memory-type words.
// R4 - Error completion uses the vector word's low byte.
// R5 - Good completion uses the vector word's high byte.
// R6 - Interrupt at the three-bit level; level zero only without interrupt.
// R7 - Address modifier byte must be zero.
// R8 - Memory type must be binary 11, short I/O.
// R9 - Transfer type field must be zero.
// R10 - 32-bit buffer field from two words is the destination offset.
// R11 - Host should pick an offset inside host usable space.
// R12 - Never move more bytes than the maximum length allows.
// R13 - Write a 16-bit status word; zero means success.
// R14 - Write the parameter list into short I/O from the offset.
// R15 - Dumped list uses the initialization block word layout.
// R16 - Host submits only via master command entry to queue zero.
// R17 - List and status are written before the interrupt is raised.
`timescale 1ns/10ps
`default_nettype none
module dump_init_params_cmd
  import dump_init_pkg::*;
(
  input wire logic clk, // 25 MHz clock
  input wire logic rst, // synchronous reset, high
  input wire logic start, // one-cycle command start
  output logic blk_rd, // parameter block read strobe
  output logic [3:0] blk_addr, // parameter block word index
  input wire logic [15:0] blk_rdata, // block data, cycle after strobe
  output logic blk_wr, // parameter block write strobe
  output logic [15:0] blk_wdata, // block write data
  output logic [4:0] list_idx, // parameter list word index
  input wire logic [15:0] list_word, // list word at list_idx, same cycle
  output logic sio_wr, // short I/O write strobe
  output logic [31:0] sio_addr, // short I/O byte offset
  output logic [15:0] sio_wdata, // short I/O write data
  output logic irq, // completion interrupt request, level
  output logic [2:0] irq_level, // bus interrupt level
  output logic [7:0] irq_vector, // interrupt vector
  input wire logic irq_ack, // host acknowledge of the interrupt
  output logic busy, // command in progress
  output logic done // one-cycle completion pulse
);
  typedef enum logic [2:0] {IDLE, FETCH, CHECK, COPY, STATUS, FINISH} state_t;
  state_t state_ff;
  state_t nxt_state;
  logic [3:0] rd_idx_ff;
  logic rd_pend_ff;
  logic [3:0] cap_idx_ff;
  // Block words held for the check and the copy.
  logic [15:0] cmd_ff;
  logic [15:0] opt_ff;
  logic [15:0] vec_ff;
  logic [15:0] irq_priority_level_ff;
  logic [15:0] memtype_ff;
  logic [31:0] buf_ff;
  logic [31:0] len_ff;
  logic [4:0] cnt_ff;
  logic [31:0] moved_ff;
  logic [15:0] st_ff;
  // Output registers.
  logic blk_rd_ff;
  logic blk_wr_ff;
  logic sio_wr_ff;
  logic irq_ff;
  logic busy_ff;
  logic done_ff;
  logic [3:0] blk_addr_ff;
  logic [15:0] blk_wdata_ff;
  logic [15:0] sio_wdata_ff;
  logic [31:0] sio_addr_ff;
  logic [2:0] irq_level_ff;
  logic [7:0] irq_vector_ff;

  // ==========================================================
  // Validation
  // The block is judged as a whole once all words are held, so a bad word
  // in the code, option, level or memory-type fields refuses the command before any short I/O write is made.
  // R1 code check
  wire code_ok = (cmd_ff == CMD_DUMP_INIT);
  // R3 reserved bits
  wire opt_rsv_ok = ((opt_ff & OPT_RSV_MASK) == 16'h0000);
  wire level_rsv_ok = ((irq_priority_level_ff & IRQ_PRIORITY_LEVEL_RSV_MASK) == 16'h0000);
  wire memtype_rsv_ok = ((memtype_ff & MEMTYPE_RSV_MASK) == 16'h0000);
  wire rsv_ok = opt_rsv_ok && level_rsv_ok && memtype_rsv_ok;
  // R7 modifier zero
  wire am_ok = ((memtype_ff & MEMTYPE_AM_MASK) == 16'h0000);
  // R8 short I/O type
  wire memory_space_ok = ((memtype_ff & MEMORY_SPACE_SELECT_MASK) == MEMORY_SPACE_SHORT_IO);
  // R9 transfer type zero
  wire transfer_kind_ok = ((memtype_ff & TRANSFER_KIND_SELECT_MASK) == 16'h0000);
  // R2 enable bit
  wire completion_irq_enable = opt_ff[OPT_IRQ_ENABLE_BIT];
  // R6 level zero rule
  wire level_ok = !(completion_irq_enable && (irq_priority_level_ff[2:0] == 3'h0));
  wire param_ok = rsv_ok && am_ok && memory_space_ok && transfer_kind_ok && level_ok;
  wire [15:0] check_status = !code_ok ? ST_BAD_CODE :
                             !param_ok ? ST_BAD_PARAM : ST_OK;
  // R12 length limit
  wire [31:0] nxt_moved = moved_ff + BYTES_PER_WORD;
  wire room = (nxt_moved <= len_ff);
  wire list_end = (cnt_ff == LIST_WORDS);
  wire fetch_last = rd_pend_ff && (cap_idx_ff == LAST_IN_WORD);
  wire fetch_issue = (state_ff == FETCH) && (rd_idx_ff <= LAST_IN_WORD);
  // R14 list word step
  wire copy_step = (state_ff == COPY) && !list_end && room;
  // R12 list cut short
  wire copy_cut = (state_ff == COPY) && !list_end && !room;
  // R17 completion after status
  wire complete = (state_ff == FINISH) && blk_wr_ff;
  // R4 R5 vector select
  wire [7:0] sel_vector = (st_ff == ST_OK) ? vec_ff[15:8] : vec_ff[7:0];

  // ==========================================================
  // Sequencer
  // A start outside IDLE is ignored, and FINISH holds until a raised
  // completion interrupt has been acknowledged.
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      IDLE: if (start) nxt_state = FETCH;
      FETCH: if (fetch_last) nxt_state = CHECK;
      CHECK: nxt_state = (check_status == ST_OK) ? COPY : STATUS;
      COPY: if (list_end || !room) nxt_state = STATUS;
      STATUS: nxt_state = FINISH;
      FINISH: if (!complete && (!irq_ff || irq_ack)) nxt_state = IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state_ff <= IDLE;
    else
      state_ff <= nxt_state;
  end

  // ==========================================================
  // Block fetch
  // Reads are issued back to back; the index and its pending flag follow
  // the strobe so each word is caught in the cycle its data stands.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_idx_ff <= 4'h0;
      rd_pend_ff <= 1'b0;
      cap_idx_ff <= 4'h0;
      blk_rd_ff <= 1'b0;
      blk_addr_ff <= 4'h0;
    end
    else
    begin
      blk_rd_ff <= 1'b0;
      rd_pend_ff <= blk_rd_ff;
      cap_idx_ff <= blk_addr_ff;
      if (state_ff == IDLE && start)
        rd_idx_ff <= W_CMD;
      else if (fetch_issue)
      begin
        blk_rd_ff <= 1'b1;
        blk_addr_ff <= rd_idx_ff;
        rd_idx_ff <= rd_idx_ff + 4'h1;
      end
      if (state_ff == STATUS)
        blk_addr_ff <= W_STATUS;
    end
  end

  // ==========================================================
  // Block capture
  // Only the words the command uses are kept; the rest are passed over.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cmd_ff <= 16'h0000;
      opt_ff <= 16'h0000;
      vec_ff <= 16'h0000;
      irq_priority_level_ff <= 16'h0000;
      memtype_ff <= 16'h0000;
      buf_ff <= 32'h00000000;
      len_ff <= 32'h00000000;
    end
    else if (rd_pend_ff)
    begin
      unique case (cap_idx_ff)
        W_CMD: cmd_ff <= blk_rdata;
        W_OPT: opt_ff <= blk_rdata;
        W_VEC: vec_ff <= blk_rdata;
        W_IRQ_PRIORITY_LEVEL: irq_priority_level_ff <= blk_rdata;
        W_MEMTYPE: memtype_ff <= blk_rdata;
        // R10 offset words
        W_BUF_HI: buf_ff[31:16] <= blk_rdata;
        W_BUF_LO: buf_ff[15:0] <= blk_rdata;
        W_LEN_HI: len_ff[31:16] <= blk_rdata;
        W_LEN_LO: len_ff[15:0] <= blk_rdata;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // List copy and status
  // The length check runs before each word, so a short length ends the
  // list on a whole word and marks the status as truncated.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_ff <= 5'h00;
      moved_ff <= 32'h00000000;
      st_ff <= ST_OK;
      sio_wr_ff <= 1'b0;
      sio_addr_ff <= 32'h00000000;
      sio_wdata_ff <= 16'h0000;
      blk_wr_ff <= 1'b0;
      blk_wdata_ff <= 16'h0000;
    end
    else
    begin
      sio_wr_ff <= 1'b0;
      blk_wr_ff <= 1'b0;
      // The status starts from the verdict of the block check.
      if (state_ff == CHECK)
      begin
        cnt_ff <= 5'h00;
        moved_ff <= 32'h00000000;
        st_ff <= check_status;
      end
      // R14 R15 list write
      if (copy_step)
      begin
        sio_wr_ff <= 1'b1;
        sio_addr_ff <= buf_ff + moved_ff;
        sio_wdata_ff <= list_word;
        moved_ff <= nxt_moved;
        cnt_ff <= cnt_ff + 5'h01;
      end
      // R12 truncated list
      if (copy_cut)
        st_ff <= ST_SHORT_LEN;
      // R13 status word
      if (state_ff == STATUS)
      begin
        blk_wr_ff <= 1'b1;
        blk_wdata_ff <= st_ff;
      end
    end
  end

  // ==========================================================
  // Completion interrupt
  // Done and the interrupt rise one cycle after the status write strobe,
  // by which time the status word is stored in the block.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq_ff <= 1'b0;
      irq_level_ff <= 3'h0;
      irq_vector_ff <= 8'h00;
      done_ff <= 1'b0;
      busy_ff <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      busy_ff <= (nxt_state != IDLE);
      // R17 after status write
      if (complete)
      begin
        done_ff <= 1'b1;
        // R2 enable gate
        irq_ff <= completion_irq_enable;
        // R6 level
        irq_level_ff <= irq_priority_level_ff[2:0];
        // R4 R5 vector
        irq_vector_ff <= sel_vector;
      end
      // A new completion wins over an acknowledge in the same cycle.
      else if (irq_ack)
        irq_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Output drive
  // Every output is a register copy; the list index is the copy counter.
  assign list_idx = cnt_ff;
  assign blk_rd = blk_rd_ff;
  assign blk_addr = blk_addr_ff;
  assign blk_wr = blk_wr_ff;
  assign blk_wdata = blk_wdata_ff;
  assign sio_wr = sio_wr_ff;
  assign sio_addr = sio_addr_ff;
  assign sio_wdata = sio_wdata_ff;
  assign irq = irq_ff;
  assign irq_level = irq_level_ff;
  assign irq_vector = irq_vector_ff;
  assign busy = busy_ff;
  assign done = done_ff;
endmodule
`default_nettype wire

// ---- dv/dump_init_asserts.sv ----
// Purpose: Port assertions for the dump command handler.
// Assumes: One clock domain with a synchronous reset.
// Notes: Bound into every handler instance.
`timescale 1ns/10ps
`default_nettype none
module dump_init_asserts
  import dump_init_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic start, // go
  input wire logic busy, // busy
  input wire logic blk_rd, // read
  input wire logic [3:0] blk_addr, // index
  input wire logic blk_wr, // write
  input wire logic [15:0] blk_wdata, // status
  input wire logic sio_wr, // list write
  input wire logic [31:0] sio_addr, // offset
  input wire logic irq, // request
  input wire logic irq_ack, // ack
  input wire logic [7:0] irq_vector, // vector
  input wire logic done // done
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_fetch_first: assert property (start && !busy |-> ##[1:3] blk_rd && blk_addr == W_CMD)
    else $error("block fetch did not begin at word zero");
  a_rd_stride: assert property (blk_rd && blk_addr < LAST_IN_WORD |=> blk_rd && blk_addr == $past(blk_addr) + 4'h1)
    else $error("block words not read in order");
  a_sio_busy: assert property (sio_wr |-> busy)
    else $error("list write outside a command");
  a_sio_stride: assert property (sio_wr && $past(sio_wr) |-> sio_addr == $past(sio_addr) + 32'h2)
    else $error("list offsets not ascending by two");
  a_status_addr: assert property (blk_wr |-> blk_addr == W_STATUS ##1 done)
    else $error("status write misplaced");
  a_done_status: assert property (done |-> $past(blk_wr) && !sio_wr)
    else $error("completion without status first");
  a_irq_rise: assert property ($rose(irq) |-> done)
    else $error("interrupt rose without completion");
  a_irq_hold: assert property (irq && !irq_ack |=> irq)
    else $error("interrupt dropped before ack");
  a_ack_clear: assert property (irq_ack && !done |=> !irq || done)
    else $error("ack did not clear interrupt");
  a_vec_change: assert property ($changed(irq_vector) |-> done)
    else $error("vector changed outside completion");
  c_irq: cover property (done && irq);
  c_ok: cover property (blk_wr && blk_wdata == ST_OK);
  c_short: cover property (blk_wr && blk_wdata == ST_SHORT_LEN);
endmodule
bind dump_init_params_cmd dump_init_asserts i_chk (.clk, .rst, .start, .busy, .blk_rd,
  .blk_addr, .blk_wr, .blk_wdata, .sio_wr, .sio_addr, .irq, .irq_ack, .irq_vector, .done);
`default_nettype wire

// ---- dv/host_model.sv ----
// Purpose: Host memory holding the parameter block.
// Assumes: Word addressed, read data one cycle later.
// Notes: The bench fills the block before each start.
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic clk, // clock
  input wire logic blk_rd, // read
  input wire logic [3:0] blk_addr, // index
  output logic [15:0] blk_rdata, // data
  input wire logic blk_wr, // write
  input wire logic [15:0] blk_wdata // status
);
  logic [15:0] blk_mem [16];
  always @(posedge clk)
  begin
    blk_rdata <= blk_rd ? blk_mem[blk_addr] : ~blk_rdata;
    if (blk_wr)
      blk_mem[blk_addr] <= blk_wdata;
  end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Purpose: Self-checking bench for the dump command.
// Assumes: Host block memory lives in the host model.
// Notes: Random blocks with forced corner cases.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import dump_init_pkg::*;
  logic clk = 0, rst = 1, start = 0, irq_ack = 0;
  logic blk_rd, blk_wr, sio_wr, irq, busy, done;
  logic [3:0] blk_addr;
  logic [15:0] blk_rdata, blk_wdata, sio_wdata, list_word, st, lbase = 16'h0;
  logic [4:0] list_idx;
  logic [31:0] sio_addr, bufa, seed = 32'hC4DDB366;
  logic [2:0] irq_level;
  logic [7:0] irq_vector;
  logic [15:0] w [12];
  int errors = 0, checks = 0, nw, nd, cyc = 0;
  always #20 clk = ~clk;
  assign list_word = lbase ^ {11'h0, list_idx};
  dump_init_params_cmd i_dut (.clk, .rst, .start, .blk_rd, .blk_addr, .blk_rdata, .blk_wr,
    .blk_wdata, .list_idx, .list_word, .sio_wr, .sio_addr, .sio_wdata, .irq, .irq_level,
    .irq_vector, .irq_ack, .busy, .done);
  host_model i_host (.clk, .blk_rd, .blk_addr, .blk_rdata, .blk_wr, .blk_wdata);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [15:0] exp_st();
    if (w[0] !== CMD_DUMP_INIT)
      return ST_BAD_CODE;
    if ((w[1] & OPT_RSV_MASK) != 0 || (w[5] & IRQ_PRIORITY_LEVEL_RSV_MASK) != 0
        || w[7] != MEMORY_SPACE_SHORT_IO || (w[1][0] && w[5][2:0] == 3'h0))
      return ST_BAD_PARAM;
    if ({w[10], w[11]} < 32'h00000028)
      return ST_SHORT_LEN;
    return ST_OK;
  endfunction
  always @(negedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      errors++;
      end_of_test();
    end
    nd += done;
    if (sio_wr === 1'b1)
    begin
      check(sio_addr, bufa + 2 * nw);
      check({16'h0, sio_wdata}, {16'h0, lbase ^ nw[15:0]});
      nw++;
    end
  end
  task automatic run_cmd();
    for (int k = 0; k < 12; k++)
      i_host.blk_mem[k] = w[k];
    st = exp_st();
    nw = 0;
    nd = 0;
    bufa = {w[8], w[9]};
    lbase = $random(seed);
    @(posedge clk) start <= 1;
    @(posedge clk) start <= 0;
    repeat (4) @(posedge clk);
    start <= 1;
    @(posedge clk) start <= 0;
    for (int t = 0; t < 100 && done !== 1'b1; t++)
      @(negedge clk);
    check(i_host.blk_mem[2], st);
    check(nw, st == ST_OK ? 20 : st == ST_SHORT_LEN ? {w[10], w[11]} / 2 : 0);
    check(irq, w[1][0]);
    if (w[1][0])
    begin
      check(irq_level, w[5][2:0]);
      check(irq_vector, st == ST_OK ? w[4][15:8] : w[4][7:0]);
    end
    @(posedge clk) irq_ack <= 1;
    @(posedge clk) irq_ack <= 0;
    @(negedge clk) check(irq, 0);
    check(nd, 1);
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 30; i++)
    begin
      for (int k = 0; k < 12; k++)
        w[k] = $random(seed);
      w[0] = CMD_DUMP_INIT;
      w[1] &= 16'h0001;
      w[5] = {13'h0, w[5][2:0] | 3'h1};
      w[7] = MEMORY_SPACE_SHORT_IO;
      w[10] = 16'h0;
      w[11] = i == 0 ? 16'h0028 : 16'h0100;
      case (i % 6)
        1: w[0] = 16'h0044;
        2: w[1 + 4 * (i % 4 / 2)][3 + i % 13] = 1'b1;
        3: w[5] = 16'h0;
        4: w[11] = i + 11;
        5: w[7] ^= 16'h1 << (i / 6 * 2 + 5);
        default: ;
      endcase
      run_cmd();
    end
    end_of_test();
  end
endmodule
`default_nettype wire
